// *** boot_pkg.sv ***
`default_nettype none
package boot_pkg;
  // Clock, timing and image size.
  localparam int CLK_MHZ       = 20;
  localparam int RST_PULSE_NS  = 10000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC    = 4;
  localparam int IMAGE_BYTES   = 65536;
  // Host port register offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_RAM    = 8'h0C;
  localparam logic [7:0] REG_FLASH  = 8'h10;
  // Control bits.
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_COPY   = 1;
  localparam int CTRL_IMG_LO = 2;
  // Status bits.
  localparam int ST_MAN    = 0;
  localparam int ST_BUSY   = 1;
  localparam int ST_RUN    = 2;
  localparam int ST_PAGE   = 3;
  localparam int ST_MAP_LO = 4;
  // Memory layout, map modes and sequencer states.
  localparam logic [1:0]  RUN_REGION = 2'h3;
  localparam logic [17:0] CFG_ADDR   = 18'h3FFF8;
  localparam int          CFG_PAGE_N = 1;
  localparam int          CFG_MAP_LO = 2;
  localparam logic [9:0]  IO_PAGE    = 10'h000;
  localparam logic [17:0] ADDR_RST   = 18'h00000;
  typedef enum logic [1:0] {MAP_256K, MAP_128K, MAP_64K} map_t;
  localparam map_t MAP_RST = MAP_256K;
  typedef enum {S_SETTLE, S_DECIDE, S_COPY, S_INTERACT, S_HCOPY,
                S_CFG, S_PULSE, S_RUN} state_t;
endpackage : boot_pkg
`default_nettype wire

// *** copy_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface copy_if;
  logic        start;
  logic        busy;
  logic        done;
  logic        wr;
  logic [15:0] offset;
  logic [7:0]  data;
  logic [7:0]  fdata;
  modport ctrl   (output start, fdata, input busy, done, wr, offset, data);
  modport engine (input start, fdata, output busy, done, wr, offset, data);
endinterface : copy_if
`default_nettype wire

// *** image_copier.sv ***
`timescale 1ns/10ps
`default_nettype none
module image_copier #(
  parameter int BYTES = boot_pkg::IMAGE_BYTES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Copy control.
  copy_if.engine   cp
);
  import boot_pkg::*;

  typedef enum {C_IDLE, C_FETCH, C_STORE} cstate_t;

  localparam logic [15:0] LAST = 16'(BYTES - 1);

  if (BYTES < 2 || BYTES > 65536) begin : g_bad
    $error("image_copier: BYTES out of range");
  end

  cstate_t     st_reg;
  logic [15:0] off_reg;
  logic [7:0]  data_reg;
  logic        wr_reg;
  logic        done_reg;

  // One byte takes two cycles: flash address settles, then RAM is written.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_reg <= C_IDLE;
    end else begin
      unique case (st_reg)
        C_IDLE:  if (cp.start) st_reg <= C_FETCH;
        C_FETCH: st_reg <= C_STORE;
        C_STORE: st_reg <= (off_reg == LAST) ? C_IDLE : C_FETCH;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      off_reg  <= 16'h0000;
      data_reg <= 8'h00;
      wr_reg   <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      wr_reg   <= st_reg == C_FETCH;
      done_reg <= st_reg == C_STORE && off_reg == LAST;
      if (st_reg == C_FETCH) data_reg <= cp.fdata;
      if (st_reg == C_IDLE) off_reg <= 16'h0000;
      else if (st_reg == C_STORE) off_reg <= off_reg + 16'h0001;
    end
  end

  assign cp.busy   = st_reg != C_IDLE;
  assign cp.offset = off_reg;
  assign cp.data   = data_reg;
  assign cp.wr     = wr_reg;
  assign cp.done   = done_reg;
endmodule : image_copier
`default_nettype wire

// *** board_boot_phase_sequencer.sv ***
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module board_boot_phase_sequencer #(
  parameter int IMAGE_BYTES = boot_pkg::IMAGE_BYTES
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Board straps, asynchronous.
  input  wire logic        interactive_switch_position,
  input  wire logic        file_select_high_jumper,
  input  wire logic        file_select_low_jumper,
  input  wire logic        autoload_inhibit_jumper,
  // Host command port.
  input  wire logic [7:0]  host_addr,
  input  wire logic [31:0] host_wdata,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  output logic [31:0]      host_rdata,
  // Microcontroller bus.
  input  wire logic [17:0] mcu_addr,
  input  wire logic        mcu_wr,
  input  wire logic [7:0]  mcu_wdata,
  output logic             mcu_rst_n,
  output logic             mcu_io_sel,
  // RAM.
  output logic [17:0]      ram_addr,
  output logic [7:0]       ram_wdata,
  output logic             ram_we,
  output logic             ram_cs,
  input  wire logic [7:0]  ram_rdata,
  // Flash.
  output logic [17:0]      flash_addr,
  output logic [7:0]       flash_wdata,
  output logic             flash_we,
  input  wire logic [7:0]  flash_rdata,
  // Indicator.
  output logic             page_mode_indicator
);
  import boot_pkg::*;

  if (IMAGE_BYTES < 2 || IMAGE_BYTES > 65536) begin : g_bad
    $error("board_boot_phase_sequencer: IMAGE_BYTES out of range");
  end
  if (RST_PULSE_CYC > 65535) begin : g_bad_pulse
    $error("board_boot_phase_sequencer: reset pulse too long");
  end

  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
  localparam logic [15:0] PULSE_LAST  = 16'(RST_PULSE_CYC - 1);

  // Strap synchronisers: three stages, a change counts once stages two and three agree.
  logic [3:0] pin_raw;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] pin_reg;

  assign pin_raw = {autoload_inhibit_jumper, file_select_high_jumper,
                    file_select_low_jumper, interactive_switch_position};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
        sync3_reg[i] <= 1'b0;
        pin_reg[i]   <= 1'b0;
      end else begin
        sync1_reg[i] <= pin_raw[i];
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
        if (sync2_reg[i] == sync3_reg[i]) pin_reg[i] <= sync3_reg[i];
      end
    end
  end

  logic       sw_man;
  logic       inhibit;
  logic [1:0] jsel;

  assign sw_man  = pin_reg[0];
  assign jsel    = pin_reg[2:1];
  assign inhibit = pin_reg[3];

  // Copy engine.
  copy_if cp ();

  image_copier #(
    .BYTES (IMAGE_BYTES)
  ) u_copy (
    .mclk (mclk),
    .nrst (nrst),
    .cp   (cp)
  );

  state_t      state_reg;
  logic [15:0] cnt_reg;
  logic [1:0]  img_reg;
  logic        start_reg;
  logic        page_reg;
  map_t        map_reg;
  logic [17:0] addr_reg;
  logic [31:0] rdata_reg;

  // Host decode; writes and RAM/flash reads are only served while interactive, status and address reads always.
  logic inter;
  logic wr_ctl;
  logic run_cmd;
  logic copy_cmd;
  logic ram_hwr;
  logic ram_hrd;
  logic fl_hwr;
  logic fl_hrd;

  assign inter    = state_reg == S_INTERACT;
  assign wr_ctl   = inter && host_wr && host_addr == REG_CTRL;
  assign run_cmd  = wr_ctl && host_wdata[CTRL_RUN];
  assign copy_cmd = wr_ctl && host_wdata[CTRL_COPY] && !run_cmd;
  assign ram_hwr  = inter && host_wr && host_addr == REG_RAM;
  assign ram_hrd  = inter && host_rd && host_addr == REG_RAM;
  assign fl_hwr   = inter && host_wr && host_addr == REG_FLASH;
  assign fl_hrd   = inter && host_rd && host_addr == REG_FLASH;

  // Phase sequencer.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg <= S_SETTLE;
    end else begin
      unique case (state_reg)
        S_SETTLE: if (cnt_reg == SETTLE_LAST) state_reg <= S_DECIDE;
        S_DECIDE: begin
          if (sw_man) state_reg <= S_INTERACT;
          else if (inhibit) state_reg <= S_CFG;
          else state_reg <= S_COPY;
        end
        S_COPY: if (cp.done) state_reg <= S_CFG;
        S_INTERACT: begin
          if (run_cmd) state_reg <= S_CFG;
          else if (copy_cmd) state_reg <= S_HCOPY;
        end
        S_HCOPY: if (cp.done) state_reg <= S_INTERACT;
        S_CFG:   state_reg <= S_PULSE;
        S_PULSE: if (cnt_reg == PULSE_LAST) state_reg <= S_RUN;
        S_RUN:   state_reg <= S_RUN;
      endcase
    end
  end

  // Shared dwell counter, cleared at the end of the settle phase and in the config phase.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
    end else if ((state_reg == S_SETTLE && cnt_reg == SETTLE_LAST) ||
                 state_reg == S_CFG) begin
      cnt_reg <= 16'h0000;
    end else if (state_reg == S_SETTLE || state_reg == S_PULSE) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Image choice and copy start.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      img_reg   <= 2'h0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (state_reg == S_DECIDE && !sw_man && !inhibit) begin
        img_reg   <= jsel;
        start_reg <= 1'b1;
      end else if (copy_cmd) begin
        img_reg   <= host_wdata[CTRL_IMG_LO +: 2];
        start_reg <= 1'b1;
      end
    end
  end

  assign cp.start = start_reg;
  assign cp.fdata = flash_rdata;

  // Bus mode and map are caught once, just before the self-reset, and held.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      page_reg <= 1'b0;
      map_reg  <= MAP_RST;
    end else if (state_reg == S_CFG) begin
      page_reg <= !ram_rdata[CFG_PAGE_N];
      unique case (ram_rdata[CFG_MAP_LO +: 2])
        2'h0:    map_reg <= MAP_256K;
        2'h1:    map_reg <= MAP_128K;
        default: map_reg <= MAP_64K;
      endcase
    end
  end

  // Host address pointer auto-increments on each data access.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      addr_reg <= ADDR_RST;
    end else if (inter && host_wr && host_addr == REG_ADDR) begin
      addr_reg <= host_wdata[17:0];
    end else if (ram_hwr || ram_hrd || fl_hwr || fl_hrd) begin
      addr_reg <= addr_reg + 18'h00001;
    end
  end

  // Read data stands only in the cycle after the strobe.
  logic [31:0] status;

  always_comb begin
    status                      = 32'h00000000;
    status[ST_MAN]              = inter;
    status[ST_BUSY]             = cp.busy;
    status[ST_RUN]              = state_reg == S_RUN;
    status[ST_PAGE]             = page_reg;
    status[ST_MAP_LO +: 2]      = map_reg;
  end

  always_ff @(posedge mclk) begin
    if (!nrst || !host_rd) begin
      rdata_reg <= 32'h00000000;
    end else begin
      unique case (host_addr)
        REG_STATUS: rdata_reg <= status;
        REG_ADDR:   rdata_reg <= {14'h0000, addr_reg};
        REG_RAM:    rdata_reg <= inter ? {24'h000000, ram_rdata} : 32'h00000000;
        REG_FLASH:  rdata_reg <= inter ? {24'h000000, flash_rdata} : 32'h00000000;
        default:    rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign host_rdata = rdata_reg;

  // Memory routing. The run-phase decode is combinational so the
  // microcontroller sees no added wait states.
  logic        run;
  logic [17:0] mapped;

  assign run        = state_reg == S_RUN;
  assign mcu_io_sel = run && mcu_addr[17:8] == IO_PAGE;

  always_comb begin
    unique case (map_reg)
      MAP_256K: mapped = mcu_addr;
      MAP_128K: mapped = {1'b1, mcu_addr[16:0]};
      default:  mapped = {RUN_REGION, mcu_addr[15:0]};
    endcase
  end

  always_comb begin
    ram_addr  = addr_reg;
    ram_wdata = host_wdata[7:0];
    ram_we    = ram_hwr;
    ram_cs    = 1'b1;
    unique case (state_reg)
      S_RUN: begin
        ram_addr  = mapped;
        ram_wdata = mcu_wdata;
        ram_cs    = !mcu_io_sel;
        ram_we    = mcu_wr && !mcu_io_sel;
      end
      S_CFG: begin
        ram_addr = CFG_ADDR;
        ram_we   = 1'b0;
      end
      S_COPY, S_HCOPY: begin
        ram_addr  = {RUN_REGION, cp.offset};
        ram_wdata = cp.data;
        ram_we    = cp.wr;
      end
      default: begin
      end
    endcase
  end

  assign flash_addr  = (state_reg == S_COPY || state_reg == S_HCOPY) ?
                       {img_reg, cp.offset} : addr_reg;
  assign flash_wdata = host_wdata[7:0];
  assign flash_we    = fl_hwr;

  // Microcontroller held in reset through setup and the pulse.
  assign mcu_rst_n           = run;
  assign page_mode_indicator = run && page_reg;

  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_auto_go;
    state_reg == S_DECIDE && !sw_man && !inhibit;
  endsequence

  sequence s_pulse;
    !mcu_rst_n [*8];
  endsequence

  property p_man_mode;
    state_reg == S_DECIDE && sw_man |=> state_reg == S_INTERACT;
  endproperty
  a_man_mode: assert property (p_man_mode)
    else $error("switch in manual did not enter interactive");

  property p_auto_copy;
    s_auto_go |=> ##1 state_reg == S_COPY && cp.busy;
  endproperty
  a_auto_copy: assert property (p_auto_copy)
    else $error("autoload did not start the copy");

  property p_img_sel;
    s_auto_go |=> ##2 flash_addr[17:16] == $past(jsel, 3);
  endproperty
  a_img_sel: assert property (p_img_sel)
    else $error("copied image differs from jumpers");

  property p_img_zero;
    s_auto_go and jsel == 2'h0 |=> ##2 flash_addr[17:16] == 2'h0;
  endproperty
  a_img_zero: assert property (p_img_zero)
    else $error("no jumpers did not select image zero");

  property p_inhibit;
    state_reg == S_DECIDE && !sw_man && inhibit |=> state_reg == S_CFG ##1 !cp.busy;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit jumper did not skip the copy");

  property p_ff_region;
    cp.wr |-> ram_we && ram_addr[17:16] == RUN_REGION;
  endproperty
  a_ff_region: assert property (p_ff_region)
    else $error("copy write outside FF region");

  property p_run_cmd;
    run_cmd |=> state_reg == S_CFG ##1 state_reg == S_PULSE;
  endproperty
  a_run_cmd: assert property (p_run_cmd)
    else $error("run command did not end interactive");

  property p_host_ram;
    ram_hwr |-> ram_we && ram_addr == addr_reg ##1 addr_reg == $past(addr_reg) + 18'h00001;
  endproperty
  a_host_ram: assert property (p_host_ram)
    else $error("host RAM write misrouted");

  property p_cfg_page;
    state_reg == S_CFG |=> page_reg == !$past(ram_rdata[CFG_PAGE_N]);
  endproperty
  a_cfg_page: assert property (p_cfg_page)
    else $error("bus mode not taken from config byte");

  property p_self_reset;
    state_reg == S_CFG |-> s_pulse;
  endproperty
  a_self_reset: assert property (p_self_reset)
    else $error("self reset pulse too short");

  property p_run_decode;
    run && !mcu_io_sel |-> ram_cs && (map_reg != MAP_64K || ram_addr[17:16] == RUN_REGION);
  endproperty
  a_run_decode: assert property (p_run_decode)
    else $error("run access not decoded to RAM");

  property p_hold;
    run |=> $stable(page_reg) && $stable(map_reg) && run;
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode changed during run phase");

  property p_led;
    $rose(run) |-> page_mode_indicator == page_reg;
  endproperty
  a_led: assert property (p_led)
    else $error("page indicator wrong at run start");
endmodule : board_boot_phase_sequencer
`default_nettype wire

// *** placeholder_end.sv ***
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** board_memory_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module board_memory_model (
  // Clock.
  input  wire logic        mclk,
  // RAM side.
  input  wire logic [17:0] ram_addr,
  input  wire logic [7:0]  ram_wdata,
  input  wire logic        ram_we,
  input  wire logic        ram_cs,
  output logic [7:0]       ram_rdata,
  // Flash side.
  input  wire logic [17:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  input  wire logic        flash_we,
  output logic [7:0]       flash_rdata
);
  logic [7:0] ram   [0:262143];
  logic [7:0] flash [0:262143];
  logic [7:0] last_reg;
  initial begin
    last_reg = 8'h00;
    for (int i = 0; i < 262144; i++) begin
      flash[i] = 8'(i) ^ 8'(i >> 10) ^ 8'h3C;
    end
  end
  // A deselected RAM shows the inverse of its last byte, so stale data never looks valid.
  assign ram_rdata   = ram_cs ? ram[ram_addr] : ~last_reg;
  assign flash_rdata = flash[flash_addr];
  always @(posedge mclk) begin
    if (ram_cs) begin
      last_reg <= ram[ram_addr];
    end
    if (ram_cs && ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
    if (flash_we) begin
      flash[flash_addr] <= flash_wdata;
    end
  end
endmodule : board_memory_model
`default_nettype wire

// *** test_board_boot_phase_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_board_boot_phase_sequencer;
  import boot_pkg::*;
  localparam int IMG   = 16;
  localparam int LIMIT = 20000;
  logic        mclk, nrst, mcu_wr, mcu_rst_n, mcu_io_sel, host_wr, host_rd;
  logic        interactive_switch_position, file_select_high_jumper;
  logic        file_select_low_jumper, autoload_inhibit_jumper, page_mode_indicator;
  logic        ram_we, ram_cs, flash_we;
  logic [7:0]  host_addr, mcu_wdata, ram_wdata, ram_rdata, flash_wdata, flash_rdata, c, b;
  logic [7:0]  snap [0:IMG-1];
  logic [17:0] mcu_addr, ram_addr, flash_addr;
  logic [31:0] host_wdata, host_rdata, d;
  int          n_fail, comparisons, seed, cycles;

  board_boot_phase_sequencer #(.IMAGE_BYTES(IMG)) dut (.mclk, .nrst,
    .interactive_switch_position, .file_select_high_jumper, .file_select_low_jumper,
    .autoload_inhibit_jumper, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
    .mcu_addr, .mcu_wr, .mcu_wdata, .mcu_rst_n, .mcu_io_sel, .ram_addr, .ram_wdata,
    .ram_we, .ram_cs, .ram_rdata, .flash_addr, .flash_wdata, .flash_we, .flash_rdata,
    .page_mode_indicator);
  board_memory_model mem (.mclk, .ram_addr, .ram_wdata, .ram_we, .ram_cs, .ram_rdata,
    .flash_addr, .flash_wdata, .flash_we, .flash_rdata);

  function automatic logic [7:0] flash_exp(input logic [17:0] a);
    return a[7:0] ^ a[17:10] ^ 8'h3C;
  endfunction : flash_exp

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic host_wr_t(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    host_addr  <= a;
    host_wdata <= v;
    host_wr    <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
  endtask : host_wr_t

  task automatic host_rd_t(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    host_addr <= a;
    host_rd   <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1 v = host_rdata;
  endtask : host_rd_t

  task automatic do_reset(input logic [3:0] s);
    @(posedge mclk);
    nrst <= 1'b0;
    {interactive_switch_position, file_select_high_jumper, file_select_low_jumper,
     autoload_inhibit_jumper} <= s;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
  endtask : do_reset

  // Polls status; the reads themselves space the polls two cycles apart.
  task automatic wait_bit(input int k, input logic v, input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      host_rd_t(REG_STATUS, r);
      if (r[k] === v) return;
    end
    cmp(r[k], v);
  endtask : wait_bit

  task automatic check_run(input logic [7:0] cb);
    logic [31:0] r;
    logic [17:0] a, e;
    logic [1:0]  m;
    m = (cb[3:2] == 2'b00) ? 2'd0 : (cb[3:2] == 2'b01) ? 2'd1 : 2'd2;
    cmp(mcu_rst_n, 1'b1);
    for (int p = 0; p < 2; p++) begin
      host_rd_t(REG_STATUS, r);
      cmp(r[5:2], {m, ~cb[1], 1'b1});
      cmp(page_mode_indicator, !cb[1]);
      host_rd_t(REG_RAM, r);
      cmp(r, 32'h0);
      for (int i = 0; i < 12; i++) begin
        a = (i == 1) ? CFG_ADDR : (i == 2) ? 18'h000A5 : 18'($random(seed));
        @(posedge mclk);
        mcu_addr  <= a;
        mcu_wdata <= 8'($random(seed));
        mcu_wr    <= i[0];
        @(negedge mclk);
        e = (m == 0) ? a : (m == 1) ? {1'b1, a[16:0]} : {2'b11, a[15:0]};
        cmp(mcu_io_sel, a[17:8] == IO_PAGE);
        if (a[17:8] != IO_PAGE) begin
          cmp({ram_cs, ram_we, ram_addr}, {1'b1, i[0], e});
        end
      end
      @(posedge mclk);
      mcu_wr <= 1'b0;
    end
  endtask : check_run

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    seed = 50481;
    {nrst, host_wr, host_rd, mcu_wr, host_addr, host_wdata} = '0;
    {mcu_addr, mcu_wdata} = '0;
    {interactive_switch_position, file_select_high_jumper} = 2'b10;
    {file_select_low_jumper, autoload_inhibit_jumper} = 2'b00;
    for (int m = 0; m < 3; m++) begin
      do_reset(4'b1000);
      @(negedge mclk);
      cmp(mcu_rst_n, 1'b0);
      wait_bit(ST_MAN, 1'b1, 20);
      c = {4'h0, 2'(m), m[0], 1'b0};
      b = 8'($random(seed));
      host_wr_t(REG_ADDR, 32'(CFG_ADDR));
      host_wr_t(REG_RAM, {24'h0, c});
      host_wr_t(REG_ADDR, 32'h12340 + m);
      host_wr_t(REG_RAM, {24'h0, b});
      host_wr_t(REG_ADDR, 32'h12340 + m);
      host_rd_t(REG_RAM, d);
      cmp(d, {24'h0, b});
      host_rd_t(REG_ADDR, d);
      cmp(d, 32'h12341 + m);
      host_wr_t(REG_ADDR, 32'h3FF00 + m);
      host_wr_t(REG_FLASH, {24'h0, ~b});
      host_wr_t(REG_ADDR, 32'h3FF00 + m);
      host_rd_t(REG_FLASH, d);
      cmp(d, {24'h0, ~b});
      host_rd_t(8'hFC, d);
      cmp(d, 32'h0);
      host_wr_t(REG_CTRL, 32'((m + 1) * 4 + 2));
      repeat (2) @(posedge mclk);
      wait_bit(ST_BUSY, 1'b0, 40);
      for (int k = 0; k < IMG; k++) begin
        cmp(mem.ram[{2'b11, 16'(k)}], flash_exp({2'(m + 1), 16'(k)}));
      end
      host_wr_t(REG_CTRL, 32'h1);
      @(negedge mclk);
      cmp(mcu_rst_n, 1'b0);
      repeat (RST_PULSE_CYC) @(negedge mclk);
      cmp(mcu_rst_n, 1'b0);
      @(negedge mclk);
      cmp(mcu_rst_n, 1'b1);
      wait_bit(ST_RUN, 1'b1, 300);
      check_run(c);
    end
    for (int j = 0; j < 4; j++) begin
      c = mem.ram[CFG_ADDR];
      do_reset({1'b0, 2'(j), 1'b0});
      wait_bit(ST_RUN, 1'b1, 300);
      host_rd_t(REG_STATUS, d);
      cmp(d[ST_MAN], 1'b0);
      for (int k = 0; k < IMG; k++) begin
        cmp(mem.ram[{2'b11, 16'(k)}], flash_exp({2'(j), 16'(k)}));
      end
      check_run(c);
    end
    c = mem.ram[CFG_ADDR];
    for (int k = 0; k < IMG; k++) begin
      snap[k] = mem.ram[{2'b11, 16'(k)}];
    end
    do_reset(4'b0011);
    wait_bit(ST_RUN, 1'b1, 300);
    for (int k = 0; k < IMG; k++) begin
      cmp(mem.ram[{2'b11, 16'(k)}], snap[k]);
    end
    check_run(c);
    conclude();
  end
endmodule : test_board_boot_phase_sequencer
`default_nettype wire
